// >>> hdl/ictp_top.v
// What this block does
// - Timer A run bit starts chain or A
// - Timer idle-stop bit halts it in Idle
// - Gating applies only with internal clock
// - Prescale codes divide by 1, 8, 64, 256
// - Chain bit joins timers into 32 bits
// - Timer A source: pin rising edges or internal
// - Timer B source: own pin or internal
// - Chained: timer B run/gate/prescale/source ignored
// - Chained Idle run needs timer B idle-stop clear
// - Qualifying pin event captures selected timer value
// - Each channel buffers four captured values
// - Capture pin event wakes from Sleep/Idle
// - Channel idle-stop bit halts channel in Idle, except mode 111 wake interrupt
// - Timebase select: set A, clear B
// - Interrupt every one to four captures
// - Read-only overflow flag on capture overflow
// - Read-only buffer-not-empty flag while unread data
// - Modes: every edge, falling, rising capture
// - Modes: every 4th, every 16th rising edge
// - Mode 111: rising-edge wake interrupt only
// - Modes 000 and 110 leave channel off
// - Every-edge mode interrupts on each capture
// - Chained: timer A low word, B high
// - Chained: A clock/gate, wrap event via B
`timescale 1ns/100ps
`default_nettype none
`include "ictp_defs.vh"
module ictp_top #(
  parameter CHANNELS = 8
) (
  // Clock and reset
  input  wire        core_clk,
  input  wire        rst,
  // Avalon-MM slave
  input  wire [7:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  // Power state
  input  wire        idle_mode,
  input  wire        sleep_mode,
  // Timer pins
  input  wire        ext_clock_pin_a,
  input  wire        ext_clock_pin_b,
  input  wire        gate_pin_a,
  input  wire        gate_pin_b,
  // Capture pins
  input  wire [CHANNELS-1:0] capture_input_pin,
  // Events
  output wire [CHANNELS-1:0] capture_irq_ff,
  output reg         wake_ff,
  output reg         timer_a_wrap_ff,
  output reg         timer_b_wrap_ff
);
  reg  [15:0] ta_ctrl_ff;
  reg  [15:0] tb_ctrl_ff;
  reg  [15:0] ta_cnt_ff;
  reg  [15:0] tb_cnt_ff;
  reg  [7:0]  ta_ps_ff;
  reg  [7:0]  tb_ps_ff;
  reg         exta_d_ff;
  reg         extb_d_ff;
  reg  [31:0] nxt_readdata;
  wire [CHANNELS-1:0] ch_we;
  wire [CHANNELS-1:0] ch_pop;
  wire [CHANNELS-1:0] ch_wake;
  wire [16*CHANNELS-1:0] ch_ctrl;
  wire [16*CHANNELS-1:0] ch_head;
  integer j;

  function [7:0] ictp_ps_term;
    input [1:0] code;
    begin
      case (code)
        2'h3:    ictp_ps_term = `ICTP_PS_TERM_256;
        2'h2:    ictp_ps_term = `ICTP_PS_TERM_64;
        2'h1:    ictp_ps_term = `ICTP_PS_TERM_8;
        default: ictp_ps_term = `ICTP_PS_TERM_1;
      endcase
    end
  endfunction

  // Bus handshake: one wait cycle, accept on the second edge
  wire req    = avs_read | avs_write;
  wire wr_acc = avs_write & ~avs_waitrequest;
  wire rd_acc = avs_read & ~avs_waitrequest;

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else if (req & avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
      avs_readdata    <= nxt_readdata;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // Timer control decode
  wire chain    = ta_ctrl_ff[`ICTP_CHAIN_BIT];
  wire a_csrc   = ta_ctrl_ff[`ICTP_CSRC_BIT];
  wire b_csrc   = tb_ctrl_ff[`ICTP_CSRC_BIT];
  wire a_gate   = ta_ctrl_ff[`ICTP_GATE_BIT] & ~a_csrc;
  wire b_gate   = tb_ctrl_ff[`ICTP_GATE_BIT] & ~b_csrc;
  wire a_stop_i = idle_mode & ta_ctrl_ff[`ICTP_IDLE_BIT];
  wire b_stop_i = idle_mode & tb_ctrl_ff[`ICTP_IDLE_BIT];

  // Chained pair also obeys timer B idle-stop
  wire a_run = ta_ctrl_ff[`ICTP_RUN_BIT] & ~a_stop_i
             & ~(chain & b_stop_i);
  wire b_run = tb_ctrl_ff[`ICTP_RUN_BIT] & ~b_stop_i & ~chain;

  // Internal clock is one tick per core clock; external is a pin rise
  wire a_src = a_csrc ? (ext_clock_pin_a & ~exta_d_ff)
                      : (a_gate ? gate_pin_a : 1'b1);
  wire b_src = b_csrc ? (ext_clock_pin_b & ~extb_d_ff)
                      : (b_gate ? gate_pin_b : 1'b1);

  wire [7:0] a_term = ictp_ps_term(ta_ctrl_ff[`ICTP_PS_HI:`ICTP_PS_LO]);
  wire [7:0] b_term = ictp_ps_term(tb_ctrl_ff[`ICTP_PS_HI:`ICTP_PS_LO]);

  wire a_inc   = a_run & a_src & (ta_ps_ff == a_term);
  wire a_top   = (ta_cnt_ff == 16'hFFFF);
  wire b_top   = (tb_cnt_ff == 16'hFFFF);
  // Chained: B carries from A, so A is the low word
  wire b_inc   = chain ? (a_inc & a_top)
                       : (b_run & b_src & (tb_ps_ff == b_term));

  wire wr_ta_ctrl = wr_acc & (avs_address == `ICTP_OFF_TA_CTRL);
  wire wr_tb_ctrl = wr_acc & (avs_address == `ICTP_OFF_TB_CTRL);
  wire wr_ta_cnt  = wr_acc & (avs_address == `ICTP_OFF_TA_CNT);
  wire wr_tb_cnt  = wr_acc & (avs_address == `ICTP_OFF_TB_CNT);

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ta_ctrl_ff <= `ICTP_CTRL_RESET;
      tb_ctrl_ff <= `ICTP_CTRL_RESET;
      exta_d_ff  <= 1'b0;
      extb_d_ff  <= 1'b0;
    end else begin
      exta_d_ff <= ext_clock_pin_a;
      extb_d_ff <= ext_clock_pin_b;
      if (wr_ta_ctrl)
        ta_ctrl_ff <= avs_writedata[15:0] & `ICTP_TA_WMASK;
      if (wr_tb_ctrl)
        tb_ctrl_ff <= avs_writedata[15:0] & `ICTP_TB_WMASK;
    end
  end

  // Prescalers clear while their timer is stopped
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ta_ps_ff <= 8'h00;
      tb_ps_ff <= 8'h00;
    end else begin
      if (~a_run)
        ta_ps_ff <= 8'h00;
      else if (a_src)
        ta_ps_ff <= (ta_ps_ff == a_term) ? 8'h00 : ta_ps_ff + 8'h01;
      if (~b_run)
        tb_ps_ff <= 8'h00;
      else if (b_src)
        tb_ps_ff <= (tb_ps_ff == b_term) ? 8'h00 : tb_ps_ff + 8'h01;
    end
  end

  // Counters; a software write wins over the count step
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ta_cnt_ff <= `ICTP_CNT_RESET;
      tb_cnt_ff <= `ICTP_CNT_RESET;
    end else begin
      if (wr_ta_cnt)
        ta_cnt_ff <= avs_writedata[15:0];
      else if (a_inc)
        ta_cnt_ff <= ta_cnt_ff + 16'h0001;
      if (wr_tb_cnt)
        tb_cnt_ff <= avs_writedata[15:0];
      else if (b_inc)
        tb_cnt_ff <= tb_cnt_ff + 16'h0001;
    end
  end

  // Wrap events; the 32-bit wrap shows only on timer B
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      timer_a_wrap_ff <= 1'b0;
      timer_b_wrap_ff <= 1'b0;
      wake_ff         <= 1'b0;
    end else begin
      timer_a_wrap_ff <= a_inc & a_top & ~chain & ~wr_ta_cnt;
      timer_b_wrap_ff <= b_inc & b_top & ~wr_tb_cnt;
      wake_ff         <= |ch_wake;
    end
  end

  // Capture channels
  genvar i;
  generate
    for (i = 0; i < CHANNELS; i = i + 1) begin : g_ch
      localparam integer CTRL_ADDR = 16 + 8 * i;
      localparam integer BUF_ADDR  = CTRL_ADDR + 4;
      assign ch_we[i]  = wr_acc & (avs_address == CTRL_ADDR[7:0]);
      assign ch_pop[i] = rd_acc & (avs_address == BUF_ADDR[7:0]);
      ictp_channel u_ch (
        .core_clk          (core_clk),
        .rst               (rst),
        .ctrl_we           (ch_we[i]),
        .ctrl_wdata        (avs_writedata[15:0]),
        .pop               (ch_pop[i]),
        .ctrl_rd           (ch_ctrl[16*i +: 16]),
        .buf_head          (ch_head[16*i +: 16]),
        .timer_a_count     (ta_cnt_ff),
        .timer_b_count     (tb_cnt_ff),
        .idle_mode         (idle_mode),
        .sleep_mode        (sleep_mode),
        .capture_input_pin (capture_input_pin[i]),
        .irq_ff            (capture_irq_ff[i]),
        .wake_ff           (ch_wake[i])
      );
    end
  endgenerate

  // Read multiplexer; unmapped addresses read as zero
  always @* begin
    nxt_readdata = 32'h0000_0000;
    case (avs_address)
      `ICTP_OFF_TA_CTRL: nxt_readdata = {16'h0000, ta_ctrl_ff};
      `ICTP_OFF_TB_CTRL: nxt_readdata = {16'h0000, tb_ctrl_ff};
      `ICTP_OFF_TA_CNT:  nxt_readdata = {16'h0000, ta_cnt_ff};
      `ICTP_OFF_TB_CNT:  nxt_readdata = {16'h0000, tb_cnt_ff};
      default:           nxt_readdata = 32'h0000_0000;
    endcase
    for (j = 0; j < CHANNELS; j = j + 1) begin
      if (avs_address == (`ICTP_OFF_CH_BASE + j[7:0] * `ICTP_CH_STRIDE))
        nxt_readdata = {16'h0000, ch_ctrl[16*j +: 16]};
      if (avs_address == (`ICTP_OFF_CH_BASE + j[7:0] * `ICTP_CH_STRIDE
                          + `ICTP_CH_BUF))
        nxt_readdata = {16'h0000, ch_head[16*j +: 16]};
    end
  end
endmodule
`default_nettype wire

// >>> hdl/ictp_defs.vh
`ifndef ICTP_DEFS_VH
`define ICTP_DEFS_VH
// Register byte offsets
`define ICTP_OFF_TA_CTRL   8'h00
`define ICTP_OFF_TB_CTRL   8'h04
`define ICTP_OFF_TA_CNT    8'h08
`define ICTP_OFF_TB_CNT    8'h0C
`define ICTP_OFF_CH_BASE   8'h10
`define ICTP_CH_STRIDE     8'h08
`define ICTP_CH_BUF        8'h04
// Timer control fields
`define ICTP_RUN_BIT       15
`define ICTP_IDLE_BIT      13
`define ICTP_GATE_BIT      6
`define ICTP_PS_HI         5
`define ICTP_PS_LO         4
`define ICTP_CHAIN_BIT     3
`define ICTP_CSRC_BIT      1
// Capture channel control fields
`define ICTP_CAP_IDLE_BIT  13
`define ICTP_CAP_TSEL_BIT  7
`define ICTP_CAP_ICI_HI    6
`define ICTP_CAP_ICI_LO    5
`define ICTP_CAP_OVF_BIT   4
`define ICTP_CAP_BNE_BIT   3
`define ICTP_CAP_MODE_HI   2
`define ICTP_CAP_MODE_LO   0
// Writable masks and reset values
`define ICTP_TA_WMASK      16'hA07A
`define ICTP_TB_WMASK      16'hA072
`define ICTP_CTRL_RESET    16'h0000
`define ICTP_CNT_RESET     16'h0000
// Prescaler terminal counts for 1:1, 1:8, 1:64, 1:256
`define ICTP_PS_TERM_1     8'h00
`define ICTP_PS_TERM_8     8'h07
`define ICTP_PS_TERM_64    8'h3F
`define ICTP_PS_TERM_256   8'hFF
// Capture modes
`define ICTP_MODE_OFF      3'h0
`define ICTP_MODE_BOTH     3'h1
`define ICTP_MODE_FALL     3'h2
`define ICTP_MODE_RISE     3'h3
`define ICTP_MODE_RISE4    3'h4
`define ICTP_MODE_RISE16   3'h5
`define ICTP_MODE_UNUSED   3'h6
`define ICTP_MODE_WAKE     3'h7
`define ICTP_BUF_DEPTH     3'h4
`endif

// >>> hdl/ictp_channel.v
`timescale 1ns/100ps
`default_nettype none
`include "ictp_defs.vh"
module ictp_channel (
  // Clock and reset
  input  wire        core_clk,
  input  wire        rst,
  // Register access
  input  wire        ctrl_we,
  input  wire [15:0] ctrl_wdata,
  input  wire        pop,
  output wire [15:0] ctrl_rd,
  output wire [15:0] buf_head,
  // Time base and power state
  input  wire [15:0] timer_a_count,
  input  wire [15:0] timer_b_count,
  input  wire        idle_mode,
  input  wire        sleep_mode,
  // Pin and events
  input  wire        capture_input_pin,
  output reg         irq_ff,
  output reg         wake_ff
);
  reg        idle_stop_ff;
  reg        tsel_ff;
  reg [1:0]  ici_ff;
  reg [2:0]  mode_ff;
  reg        ovf_ff;
  reg [2:0]  cnt_ff;
  reg [1:0]  wr_ff;
  reg [1:0]  rd_ff;
  reg [15:0] mem_ff [0:3];
  reg        pin_d_ff;
  reg [3:0]  edge_ff;
  reg [1:0]  irqcnt_ff;
  reg        cap;
  integer    k;
  wire rise   = capture_input_pin & ~pin_d_ff;
  wire fall   = ~capture_input_pin & pin_d_ff;
  wire active = ~(idle_mode & idle_stop_ff);
  wire full   = (cnt_ff == `ICTP_BUF_DEPTH);
  wire stored = cap & ~full;
  wire popv   = pop & (cnt_ff != 3'h0);
  wire off_wr = ctrl_we & (ctrl_wdata[2:0] == `ICTP_MODE_OFF);
  wire lowpwr = idle_mode | sleep_mode;
  wire pin_irq = (mode_ff == `ICTP_MODE_WAKE) & lowpwr & rise;
  assign ctrl_rd  = {2'h0, idle_stop_ff, 5'h00, tsel_ff, ici_ff, ovf_ff,
                     (cnt_ff != 3'h0), mode_ff};
  assign buf_head = mem_ff[rd_ff];
  always @* begin
    case (mode_ff)
      `ICTP_MODE_BOTH:   cap = rise | fall;
      `ICTP_MODE_FALL:   cap = fall;
      `ICTP_MODE_RISE:   cap = rise;
      `ICTP_MODE_RISE4:  cap = rise & (edge_ff[1:0] == 2'h3);
      `ICTP_MODE_RISE16: cap = rise & (edge_ff == 4'hF);
      default:           cap = 1'b0;
    endcase
    cap = cap & active;
  end
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      idle_stop_ff <= 1'b0;
      tsel_ff      <= 1'b0;
      ici_ff       <= 2'h0;
      mode_ff      <= 3'h0;
      ovf_ff       <= 1'b0;
      cnt_ff       <= 3'h0;
      wr_ff        <= 2'h0;
      rd_ff        <= 2'h0;
      pin_d_ff     <= 1'b0;
      edge_ff      <= 4'h0;
      irqcnt_ff    <= 2'h0;
      irq_ff       <= 1'b0;
      wake_ff      <= 1'b0;
      for (k = 0; k < 4; k = k + 1) mem_ff[k] <= 16'h0000;
    end else begin
      pin_d_ff <= capture_input_pin;
      if (ctrl_we) begin
        idle_stop_ff <= ctrl_wdata[`ICTP_CAP_IDLE_BIT];
        tsel_ff      <= ctrl_wdata[`ICTP_CAP_TSEL_BIT];
        ici_ff       <= ctrl_wdata[`ICTP_CAP_ICI_HI:`ICTP_CAP_ICI_LO];
        mode_ff      <= ctrl_wdata[`ICTP_CAP_MODE_HI:`ICTP_CAP_MODE_LO];
      end
      if (ctrl_we)
        edge_ff <= 4'h0;
      else if (active & rise)
        edge_ff <= edge_ff + 4'h1;
      if (stored)
        mem_ff[wr_ff] <= tsel_ff ? timer_a_count : timer_b_count;
      // New overflow wins over the clear by a mode-off write
      if (cap & full)
        ovf_ff <= 1'b1;
      else if (off_wr)
        ovf_ff <= 1'b0;
      wr_ff <= wr_ff + {1'b0, stored};
      if (off_wr) begin
        rd_ff  <= wr_ff;
        cnt_ff <= {2'h0, stored};
      end else begin
        rd_ff  <= rd_ff + {1'b0, popv};
        cnt_ff <= cnt_ff + {2'h0, stored} - {2'h0, popv};
      end
      irq_ff <= 1'b0;
      if (ctrl_we)
        irqcnt_ff <= 2'h0;
      else if (stored) begin
        if ((mode_ff == `ICTP_MODE_BOTH) || (irqcnt_ff == ici_ff)) begin
          irq_ff    <= 1'b1;
          irqcnt_ff <= 2'h0;
        end else
          irqcnt_ff <= irqcnt_ff + 2'h1;
      end
      if (pin_irq)
        irq_ff <= 1'b1;
      wake_ff <= (cap & lowpwr) | pin_irq;
    end
  end
endmodule
`default_nettype wire

// >>> dv/ictp_top_sva.sv
`timescale 1ns/100ps
`default_nettype none
module ictp_top_sva #(
  parameter CHANNELS = 8
) (
  // Clock, reset and bus
  input wire logic                core_clk,
  input wire logic                rst,
  input wire logic                avs_read,
  input wire logic                avs_write,
  input wire logic [31:0]         avs_readdata,
  input wire logic                avs_waitrequest,
  // Power state and pins
  input wire logic                idle_mode,
  input wire logic                sleep_mode,
  input wire logic [CHANNELS-1:0] capture_input_pin,
  // Events
  input wire logic [CHANNELS-1:0] capture_irq_ff,
  input wire logic                wake_ff,
  input wire logic                timer_a_wrap_ff,
  input wire logic                timer_b_wrap_ff
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_answer;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  a_bus_answer: assert property (s_req |=> s_answer)
    else $error("bus answer not one wait cycle");
  a_bus_idle: assert property (!(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest dropped with no request");
  a_read_upper: assert property (!avs_waitrequest |-> avs_readdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  a_irq_edge: assert property (
    capture_irq_ff[0] |-> $past(capture_input_pin[0]) != $past(capture_input_pin[0], 2))
    else $error("capture interrupt without pin edge");
  a_irq_pulse: assert property (capture_irq_ff[0] |=> !capture_irq_ff[0])
    else $error("capture interrupt longer than one cycle");
  a_wake_edge: assert property (
    wake_ff |-> $past(capture_input_pin, 2) != $past(capture_input_pin, 3))
    else $error("wake without pin edge");
  a_wake_power: assert property (wake_ff |-> $past(idle_mode || sleep_mode, 2))
    else $error("wake outside sleep or idle");
  a_wake_pulse: assert property (wake_ff |=> !wake_ff)
    else $error("wake longer than one cycle");
  a_wrap_a_gap: assert property (timer_a_wrap_ff |=> !timer_a_wrap_ff [*8])
    else $error("timer a wrap repeats");
  a_wrap_b_gap: assert property (timer_b_wrap_ff |=> !timer_b_wrap_ff [*8])
    else $error("timer b wrap repeats");
endmodule
bind ictp_top ictp_top_sva #(.CHANNELS(CHANNELS)) u_sva (
  .core_clk(core_clk), .rst(rst), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .idle_mode(idle_mode),
  .sleep_mode(sleep_mode), .capture_input_pin(capture_input_pin),
  .capture_irq_ff(capture_irq_ff), .wake_ff(wake_ff),
  .timer_a_wrap_ff(timer_a_wrap_ff), .timer_b_wrap_ff(timer_b_wrap_ff));
`default_nettype wire

// >>> dv/ictp_pin_src.sv
`timescale 1ns/100ps
`default_nettype none
module ictp_pin_src #(
  parameter logic [7:0] GAP = 8'h09
) (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // Run request
  input  wire logic       go,
  input  wire logic [7:0] toggles,
  // Pin side
  output var  logic       pin_ff,
  output var  logic       busy_ff
);
  logic [7:0] left_ff;
  logic [7:0] wait_ff;
  // Pin holds its level between runs, so an even count leaves it at its starting level
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pin_ff <= 1'b0;
      busy_ff <= 1'b0;
      left_ff <= 8'h00;
      wait_ff <= 8'h00;
    end else if (go && !busy_ff) begin
      left_ff <= toggles;
      wait_ff <= GAP;
      busy_ff <= (toggles != 8'h00);
    end else if (busy_ff && wait_ff == 8'h00) begin
      pin_ff <= ~pin_ff;
      wait_ff <= GAP;
      left_ff <= left_ff - 8'h01;
      busy_ff <= (left_ff != 8'h01);
    end else if (busy_ff) begin
      wait_ff <= wait_ff - 8'h01;
    end
  end
endmodule
`default_nettype wire

// >>> dv/ictp_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "ictp_defs.vh"
`define CHK(nm, e, s) begin checks_done++; if ((s) !== (e)) begin miscompares++; \
  $display("mismatch %s expected %h seen %h", nm, (e), (s)); end end
module ictp_top_tb;
  localparam [7:0] TAC = `ICTP_OFF_TA_CTRL, TBC = `ICTP_OFF_TB_CTRL;
  localparam [7:0] TAN = `ICTP_OFF_TA_CNT, TBN = `ICTP_OFF_TB_CNT, CH0 = `ICTP_OFF_CH_BASE;
  localparam [7:0] CH1 = CH0 + `ICTP_CH_STRIDE, BF0 = CH0 + `ICTP_CH_BUF;
  localparam [7:0] BF1 = CH1 + `ICTP_CH_BUF;
  localparam [15:0] RUN = 16'h8000, IDL = 16'h2000, GAT = 16'h0040, CHN = 16'h0008;
  localparam [15:0] EXT = 16'h0002;
  logic        core_clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, go = 1'b0;
  logic        idle_mode = 1'b0, sleep_mode = 1'b0, ext_clk = 1'b0, gate_a = 1'b0;
  logic [7:0]  avs_address = 8'h00, toggles = 8'h00;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [15:0] ca, cb, ia, ib, q, e0;
  wire logic [31:0] avs_readdata;
  wire logic [1:0]  irq;
  wire logic        avs_waitrequest, wake, wrap_a, wrap_b, pin, busy;
  int miscompares = 0, checks_done = 0, irq_n, irq1_n, wk_n, wa_n, wb_n;
  ictp_top #(.CHANNELS(2)) dut (.core_clk(core_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .idle_mode(idle_mode),
    .sleep_mode(sleep_mode), .ext_clock_pin_a(ext_clk), .ext_clock_pin_b(ext_clk),
    .gate_pin_a(gate_a), .gate_pin_b(gate_a), .capture_input_pin({pin, pin}),
    .capture_irq_ff(irq), .wake_ff(wake), .timer_a_wrap_ff(wrap_a), .timer_b_wrap_ff(wrap_b));
  ictp_pin_src src (.core_clk(core_clk), .rst(rst), .go(go), .toggles(toggles),
    .pin_ff(pin), .busy_ff(busy));
  initial forever #12.5 core_clk = ~core_clk;
  // External clocks run free at half rate; pulse counters feed the scenarios
  always @(posedge core_clk) begin
    ext_clk <= ~ext_clk;
    irq_n += irq[0];
    irq1_n += irq[1];
    wk_n += wake;
    wa_n += wrap_a;
    wb_n += wrap_b;
  end
  task conclude;
    if (miscompares == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [15:0] d, output logic [15:0] r);
    int n;
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= {16'h0000, d};
    avs_write <= w;
    avs_read <= ~w;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 64);
    r = avs_readdata[15:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 64) begin
      miscompares++;
      conclude;
    end
  endtask
  task wr(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] j;
    bus(1'b1, a, d, j);
  endtask
  task rd(input logic [7:0] a, output logic [15:0] r);
    bus(1'b0, a, 16'h0000, r);
  endtask
  function automatic bit inr(logic [31:0] v, logic [31:0] e);
    return v + 2 >= e && v <= e + 12;
  endfunction
  task trun(input logic [15:0] a, input logic [15:0] b, input int cyc);
    wr(TAN, ia);
    wr(TBN, ib);
    wr(TBC, b);
    wr(TAC, a);
    wa_n = 0;
    wb_n = 0;
    repeat (cyc) @(posedge core_clk);
    wr(TAC, 16'h0000);
    wr(TBC, 16'h0000);
    rd(TAN, ca);
    rd(TBN, cb);
  endtask
  task fire(input logic [7:0] t);
    int n;
    irq_n = 0;
    irq1_n = 0;
    wk_n = 0;
    toggles <= t;
    go <= 1'b1;
    @(posedge core_clk);
    go <= 1'b0;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (busy !== 1'b0 && n < 2000);
    repeat (4) @(posedge core_clk);
    if (n >= 2000) begin
      miscompares++;
      conclude;
    end
  endtask
  // Channel 0 captures timer A, channel 1 captures timer B
  task cap(input logic [15:0] c, input logic [7:0] t);
    wr(CH0, 16'h0000);
    wr(CH1, 16'h0000);
    wr(CH0, c | 16'h0080);
    wr(CH1, c);
    fire(t);
  endtask
  task drain(input logic [15:0] step);
    int i;
    rd(BF0, e0);
    for (i = 1; i < 4; i++) begin
      rd(BF0, q);
      `CHK("entry", e0 + step, q)
      e0 = q;
    end
  endtask
  task t_regs;
    logic [7:0] ad [0:5] = '{TAC, TBC, TAN, TBN, CH0, 8'hF0};
    int k;
    for (k = 0; k < 6; k++) begin
      rd(ad[k], q);
      `CHK("reset", 16'h0000, q)
    end
    wr(TAC, 16'hFFFF);
    rd(TAC, q);
    `CHK("ta_ctrl", 16'hA07A, q)
    wr(TBC, 16'hFFFF);
    rd(TBC, q);
    `CHK("tb_ctrl", 16'hA072, q)
    wr(CH0, 16'hFFFF);
    rd(CH0, q);
    `CHK("ch_ctrl", 16'h20E7, q)
    wr(8'hF0, 16'hFFFF);
    rd(8'hF0, q);
    `CHK("unmapped", 16'h0000, q)
    wr(TAC, 16'h0000);
    wr(TBC, 16'h0000);
  endtask
  task t_timer;
    int k;
    ia = 16'h0000;
    ib = 16'h0000;
    for (k = 0; k < 4; k++) begin
      trun(RUN | (k << 4), 16'h0000, 1024);
      `CHK("prescale", 1'b1, inr(ca, 1024 >> ((k == 3) ? 8 : 3 * k)))
    end
    trun(RUN | GAT, 16'h0000, 256);
    `CHK("gated", 16'h0000, ca)
    trun(RUN | GAT | EXT, RUN | GAT | EXT, 256);
    `CHK("ext_a", 1'b1, inr(ca, 128))
    `CHK("ext_b", 1'b1, inr(cb, 128))
    gate_a <= 1'b1;
    trun(RUN | GAT, 16'h0000, 256);
    `CHK("gate_open", 1'b1, inr(ca, 256))
    gate_a <= 1'b0;
    idle_mode <= 1'b1;
    trun(RUN | IDL, RUN | 16'h0010, 256);
    `CHK("idle_a", 16'h0000, ca)
    `CHK("idle_b", 1'b1, inr(cb, 32))
    idle_mode <= 1'b0;
    trun(16'h0000, RUN | IDL, 256);
    `CHK("stopped", 16'h0000, ca)
    `CHK("busy_b", 1'b1, inr(cb, 256))
    ia = 16'hFFF0;
    trun(RUN, 16'h0000, 64);
    `CHK("wrap_a", 1, wa_n)
    ib = 16'hFFFF;
    trun(RUN | CHN, GAT | EXT | 16'h0030, 64);
    `CHK("chain_lo", 1'b1, inr(ca, 16'h0030))
    `CHK("chain_hi", 16'h0000, cb)
    `CHK("chain_wrap", {32'd1, 32'd0}, {wb_n, wa_n})
    ib = 16'h0005;
    idle_mode <= 1'b1;
    trun(RUN | CHN, IDL, 64);
    `CHK("chain_idle", {16'h0005, 16'hFFF0}, {cb, ca})
    idle_mode <= 1'b0;
  endtask
  task t_cap;
    int k;
    wr(TAN, 16'h0000);
    wr(TBN, 16'h5A5A);
    wr(TAC, RUN);
    cap(16'h0003, 8);
    `CHK("irq", 4, irq_n)
    `CHK("irq_b", 4, irq1_n)
    rd(CH0, q);
    `CHK("flags", 2'b01, q[4:3])
    drain(16'd20);
    rd(BF1, q);
    `CHK("timer_b", 16'h5A5A, q)
    rd(CH0, q);
    `CHK("empty", 2'b00, q[4:3])
    cap(16'h0003, 8);
    fire(4);
    rd(CH0, q);
    `CHK("ovf", 2'b11, q[4:3])
    drain(16'd20);
    wr(CH0, 16'h0000);
    rd(CH0, q);
    `CHK("off", 2'b00, q[4:3])
    for (k = 0; k < 4; k++) begin
      cap(16'h0003 | (k << 5), 8);
      `CHK("per_irq", 4 / (k + 1), irq_n)
    end
    cap(16'h0061, 4);
    `CHK("both", 4, irq_n)
    cap(16'h0004, 32);
    `CHK("fourth", 4, irq_n)
    drain(16'd80);
    cap(16'h0005, 32);
    `CHK("sixteenth", 1, irq_n)
    cap(16'h0002, 1);
    `CHK("fall_r", 0, irq_n)
    fire(1);
    `CHK("fall_f", 1, irq_n)
    for (k = 0; k < 3; k++) begin
      cap((k == 0) ? 16'h0000 : 16'h0005 + k, 8);
      rd(CH0, q);
      `CHK("disabled", {2'b00, 32'd0}, {q[4:3], irq_n})
    end
  endtask
  task t_power;
    idle_mode <= 1'b1;
    cap(16'h0067, 4);
    rd(CH0, q);
    `CHK("pin_irq", {2'b00, 32'd2, 32'd2}, {q[4:3], irq_n, wk_n})
    cap(16'h2003, 4);
    `CHK("ch_idle", {32'd0, 32'd0}, {irq_n, wk_n})
    cap(16'h0003, 4);
    `CHK("ch_run", {32'd2, 32'd2}, {irq_n, wk_n})
    idle_mode <= 1'b0;
    sleep_mode <= 1'b1;
    cap(16'h0007, 4);
    `CHK("sleep", {32'd2, 32'd2}, {irq_n, wk_n})
    sleep_mode <= 1'b0;
  endtask
  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    t_regs;
    t_timer;
    t_cap;
    t_power;
    conclude;
  end
endmodule
`default_nettype wire
